// [stp_pkg.sv]
/*
 Shared constants and types of the speech test serial port.
 Assumes a 100 MHz system clock; every cycle count below derives from it.
*/
package stp_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int LINK_HZ = 104_000;
   localparam int SAMPLE_HZ = 8000;
   // Nominal half period rounds down, so the rate errs on the fast side
   localparam int LINK_HALF_CYC = CLK_HZ / (2 * LINK_HZ);
   localparam logic [9:0] LINK_HALF = 10'(LINK_HALF_CYC);
   localparam logic [9:0] LINK_PERIOD_LAST = 10'(2 * LINK_HALF_CYC - 1);
   localparam int SAMPLE_CYC_DEF = CLK_HZ / SAMPLE_HZ;

   // ==========================================================
   // Word format
   localparam int WORD_BITS = 13;
   localparam logic [3:0] WORD_LAST_BIT = 4'(WORD_BITS - 1);

   // ==========================================================
   // Register map and reset values
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_WORDS = 4'h8;
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam logic CTRL_SRC_RST = 1'h0;
   localparam logic [1:0] CTRL_MODE_RST = 2'h0;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_DOWN = 2'h1,
      MODE_UP = 2'h2,
      MODE_ACOUSTIC = 2'h3
   } stp_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_ALIGN = 3'h2,
      ST_SHIFT = 3'h4
   } stp_state_t;

endpackage

// [stp_sync.sv]
/*
 Three-stage input synchroniser with agreement filter.
 Assumes asynchronous inputs; output follows once stages two and three agree.
*/
`timescale 1ns/1ps
module stp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] ff1;
   logic [W-1:0] ff2;
   logic [W-1:0] ff3;

   // ==========================================================
   // Stages
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ff1 <= INIT;
         ff2 <= INIT;
         ff3 <= INIT;
      end else begin
         ff1 <= din;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // ==========================================================
   // Agreement; bits update one by one
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         dout <= INIT;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (ff2[i] == ff3[i]) begin
               dout[i] <= ff3[i];
            end
         end
      end
   end

endmodule

// [stp_port.sv]
/*
 Handset end of the speech test serial port: clock generator, word shifter,
 mode decode, test reset handling, Avalon-MM register slave.
 Assumes frameStrobe marks interleaved block boundaries on clk_sys, and that
 the codec side talks through the dn and up streams.
*/
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Words are 13-bit two's complement, most significant bit first.
// - Sender changes data on falling clock edge; receiver samples on rising edge.
// - Handset keeps the data clock high when no transfer runs.
// - Reset line asserted when low, released when high.
// - Mode lines: 00 normal, 01 downlink, 10 uplink, 11 acoustic test.
// - Handset generates the 104 kHz clock and drives clock and its data.
// - After reset release, clock only runs when data is needed or ready.
// - Uplink: first falling edge requests first bit, aligned to first block frame.
// - Downlink: first falling edge outputs first bit from first completed block.
// - In any test mode, transcoders reset at end of every reset pulse.
// - Mode may come from an air message instead of the lines.
// - Samples carry linear speech at 8000 per second each direction.
// - Only one selection method needed; the chosen method is declared.
module stp_port
   import stp_pkg::*;
#(
   parameter int SAMPLE_CYC = SAMPLE_CYC_DEF
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic ctlLine1,
   input wire logic ctlLine2,
   input wire logic rstLineN,
   input wire logic simDataIn,
   output logic linkClkOut,
   output logic linkDataOut,
   input wire logic frameStrobe,
   input wire logic dnValid,
   output logic dnReady,
   input wire logic [WORD_BITS-1:0] dnData,
   output logic upValid,
   input wire logic upReady,
   output logic [WORD_BITS-1:0] upData,
   output logic codecReset,
   output logic [1:0] testMode
);

   // ==========================================================
   // Pin synchronisers
   logic [3:0] pinsS;
   logic line1S;
   logic line2S;
   logic rstLineNS;
   logic simDataS;

   stp_sync #(.W(4), .INIT(4'h2)) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .din({ctlLine1, ctlLine2, rstLineN, simDataIn}),
      .dout(pinsS)
   );
   assign line1S = pinsS[3];
   assign line2S = pinsS[2];
   assign rstLineNS = pinsS[1];
   assign simDataS = pinsS[0];

   // ==========================================================
   // Avalon-MM slave, one wait cycle on every access
   logic ackR;
   logic ctrlSrcR;
   logic [1:0] ctrlModeR;
   logic [15:0] wordCntR;
   logic [31:0] statusWord;
   logic accTake;

   assign avs_waitrequest = (avs_read | avs_write) & ~ackR;
   assign accTake = (avs_read | avs_write) & ~ackR;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ackR <= 1'b0;
      end else begin
         ackR <= accTake;
      end
   end

   // Source bit is the declared selection method, readable back
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrlSrcR <= CTRL_SRC_RST;
         ctrlModeR <= CTRL_MODE_RST;
      end else if (avs_write && ackR && avs_address == REG_CTRL) begin
         ctrlSrcR <= avs_writedata[CTRL_SRC_BIT];
         ctrlModeR <= avs_writedata[CTRL_MODE_LSB +: 2];
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         avs_readdata <= 32'h0;
      end else if (accTake && avs_read) begin
         unique case (avs_address)
            REG_CTRL: avs_readdata <= {29'h0, ctrlModeR, ctrlSrcR};
            REG_STATUS: avs_readdata <= statusWord;
            REG_WORDS: avs_readdata <= {16'h0, wordCntR};
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   // ==========================================================
   // Mode decode
   stp_mode_t effMode;
   logic testSel;
   logic needInMode;
   logic needOutMode;

   always_comb begin
      if (ctrlSrcR) begin
         effMode = stp_mode_t'(ctrlModeR);
      end else begin
         effMode = stp_mode_t'({line1S, line2S});
      end
   end
   assign testSel = effMode != MODE_NORMAL;
   assign needInMode = effMode == MODE_UP || effMode == MODE_ACOUSTIC;
   assign needOutMode = effMode == MODE_DOWN || effMode == MODE_ACOUSTIC;
   assign testMode = effMode;

   // ==========================================================
   // Test reset pulse
   logic rstPrevR;
   logic pinAsserted;
   logic relEdge;
   logic armedR;

   assign pinAsserted = ~rstLineNS;
   assign relEdge = rstLineNS & ~rstPrevR;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rstPrevR <= 1'b1;
      end else begin
         rstPrevR <= rstLineNS;
      end
   end

   // No test runs until a reset pulse ends in a test mode
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         armedR <= 1'b0;
      end else if (pinAsserted || !testSel) begin
         armedR <= 1'b0;
      end else if (relEdge) begin
         armedR <= 1'b1;
      end
   end

   // Transcoder reset on every release while a test mode is selected
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         codecReset <= 1'b0;
      end else begin
         codecReset <= relEdge & testSel;
      end
   end

   // ==========================================================
   // Sample pacing, 8000 words per second
   logic [13:0] sampleCntR;
   logic sampleTick;
   stp_state_t stR;

   assign sampleTick = sampleCntR == 14'h0;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sampleCntR <= 14'h0;
      end else if (stR == ST_ALIGN || sampleCntR == 14'(SAMPLE_CYC - 1)) begin
         sampleCntR <= 14'h0;
      end else begin
         sampleCntR <= sampleCntR + 14'h1;
      end
   end

   // ==========================================================
   // Transfer control
   logic alignedR;
   logic [1:0] bufCntR;
   logic needIn;
   logic needOut;
   logic wordGo;
   logic wordDone;
   logic [9:0] phaseR;
   logic [3:0] bitR;
   logic wantInR;

   assign needIn = needInMode && bufCntR != 2'h2;
   assign needOut = needOutMode && dnValid;
   assign wordGo = stR == ST_IDLE && armedR && alignedR && sampleTick && (needIn || needOut);
   assign wordDone = stR == ST_SHIFT && phaseR == LINK_PERIOD_LAST && bitR == WORD_LAST_BIT;
   assign dnReady = wordGo && needOut;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         stR <= ST_IDLE;
      end else if (pinAsserted || !testSel) begin
         stR <= ST_IDLE;
      end else if (relEdge) begin
         stR <= ST_ALIGN;
      end else begin
         unique case (stR)
            ST_IDLE: if (wordGo) stR <= ST_SHIFT;
            ST_ALIGN: if (frameStrobe) stR <= ST_IDLE;
            ST_SHIFT: if (wordDone) stR <= ST_IDLE;
            default: stR <= ST_IDLE;
         endcase
      end
   end

   // First word waits for the first block boundary after release
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         alignedR <= 1'b0;
      end else if (pinAsserted || !testSel || relEdge) begin
         alignedR <= 1'b0;
      end else if (stR == ST_ALIGN && frameStrobe) begin
         alignedR <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         phaseR <= 10'h0;
         bitR <= 4'h0;
      end else if (stR != ST_SHIFT) begin
         phaseR <= 10'h0;
         bitR <= 4'h0;
      end else if (phaseR == LINK_PERIOD_LAST) begin
         phaseR <= 10'h0;
         bitR <= bitR + 4'h1;
      end else begin
         phaseR <= phaseR + 10'h1;
      end
   end

   // ==========================================================
   // Link clock: high at rest, low then high each bit
   logic fallNow;
   logic riseNow;

   assign fallNow = stR == ST_SHIFT && phaseR == 10'h0;
   assign riseNow = stR == ST_SHIFT && phaseR == LINK_HALF;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         linkClkOut <= 1'b1;
      end else if (stR != ST_SHIFT || pinAsserted || !testSel) begin
         linkClkOut <= 1'b1;
      end else if (fallNow) begin
         linkClkOut <= 1'b0;
      end else if (riseNow) begin
         linkClkOut <= 1'b1;
      end
   end

   // ==========================================================
   // Shifters, MSB first, out at fall, in at rise
   logic [WORD_BITS-1:0] txShiftR;
   logic [WORD_BITS-1:0] rxShiftR;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         txShiftR <= '0;
         linkDataOut <= 1'b0;
      end else if (wordGo) begin
         txShiftR <= needOut ? dnData : '0;
      end else if (fallNow && !pinAsserted && testSel) begin
         linkDataOut <= txShiftR[WORD_BITS-1];
         txShiftR <= {txShiftR[WORD_BITS-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxShiftR <= '0;
      end else if (riseNow) begin
         rxShiftR <= {rxShiftR[WORD_BITS-2:0], simDataS};
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wantInR <= 1'b0;
      end else if (wordGo) begin
         wantInR <= needIn;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wordCntR <= 16'h0;
      end else if (wordDone) begin
         wordCntR <= wordCntR + 16'h1;
      end
   end

   // ==========================================================
   // Two-entry buffer on the uplink path; a full buffer holds back the clock unless a downlink word is due
   logic [WORD_BITS-1:0] bufMem [2];
   logic bufWrR;
   logic bufRdR;
   logic push;
   logic pop;

   assign push = wordDone && wantInR;
   assign pop = upValid && upReady;
   assign upValid = bufCntR != 2'h0;
   assign upData = bufMem[bufRdR];

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bufMem[0] <= '0;
         bufMem[1] <= '0;
         bufWrR <= 1'b0;
      end else if (push) begin
         bufMem[bufWrR] <= rxShiftR;
         bufWrR <= ~bufWrR;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bufRdR <= 1'b0;
      end else if (pop) begin
         bufRdR <= ~bufRdR;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bufCntR <= 2'h0;
      end else if (push && !pop) begin
         bufCntR <= bufCntR + 2'h1;
      end else if (pop && !push) begin
         bufCntR <= bufCntR - 2'h1;
      end
   end

   assign statusWord = {25'h0, pinAsserted, bufCntR, alignedR, armedR, effMode};

   // ==========================================================
   // Checks
   localparam int HALF_INT = LINK_HALF_CYC;
   logic [10:0] lowLenR;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lowLenR <= 11'h0;
      end else if (linkClkOut) begin
         lowLenR <= 11'h0;
      end else begin
         lowLenR <= lowLenR + 11'h1;
      end
   end

   sequence wordStart_s;
      stR == ST_IDLE ##1 stR == ST_SHIFT;
   endsequence

   sequence releaseInTest_s;
      relEdge && testSel && !pinAsserted;
   endsequence

   clk_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
      stR != ST_SHIFT |=> linkClkOut)
      else $error("link clock low while idle");
   clk_low_time_a: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(linkClkOut) && $past(riseNow) |-> lowLenR == 11'(HALF_INT))
      else $error("link clock low phase wrong length");
   data_on_fall_a: assert property (@(posedge clk_sys) disable iff (reset)
      $changed(linkDataOut) |-> $fell(linkClkOut))
      else $error("data changed away from falling edge");
   mode_decode_a: assert property (@(posedge clk_sys) disable iff (reset)
      !ctrlSrcR |-> testMode == {line1S, line2S})
      else $error("mode lines decoded wrongly");
   reset_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
      pinAsserted |=> stR == ST_IDLE && linkClkOut)
      else $error("transfer kept running under reset");
   codec_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
      releaseInTest_s |=> codecReset ##1 !codecReset)
      else $error("transcoder reset pulse missing");
   word_start_a: assert property (@(posedge clk_sys) disable iff (reset)
      wordStart_s |-> alignedR && $past(needIn || needOut))
      else $error("word started without need or alignment");
   word_len_a: assert property (@(posedge clk_sys) disable iff (reset)
      wordDone |-> bitR == WORD_LAST_BIT && linkClkOut)
      else $error("word not thirteen bits");
   buf_full_a: assert property (@(posedge clk_sys) disable iff (reset)
      bufCntR == 2'h2 && !pop |=> bufCntR == 2'h2)
      else $error("buffer lost a word");

endmodule

// [stp_sim_model.sv]
/*
 Behavioural test simulator facing the handset end of the speech test port.
 Assumes the handset link clock is sampled on clk_sys; waits are shortened.
*/
`timescale 1ns/1ps
module stp_sim_model
   import stp_pkg::*;
#(
   parameter int MODE_WAIT_CYC = 300,
   parameter int RESET_LOW_CYC = 400
) (
   input wire logic clk_sys,
   input wire logic linkClkOut,
   input wire logic linkDataOut,
   output logic ctlLine1,
   output logic ctlLine2,
   output logic rstLineN,
   output logic simDataIn
);
   // ======================
   // Word queues and bit tracking
   logic [WORD_BITS-1:0] txQ[$];
   logic [WORD_BITS-1:0] rxQ[$];
   logic [WORD_BITS-1:0] txCur = '0;
   logic [WORD_BITS-1:0] rxSh = '0;
   logic clkQ = 1'b1;
   int txBit = 0;
   int rxBit = 0;
   int hold = 0;

   initial begin
      ctlLine1 = 1'b0;
      ctlLine2 = 1'b0;
      rstLineN = 1'b1;
      simDataIn = 1'b0;
   end

   always @(posedge clk_sys) begin
      clkQ <= linkClkOut;
      if (hold == 1) begin
         simDataIn <= ~simDataIn; // Released line must not keep the last bit
      end
      if (hold > 0) begin
         hold = hold - 1;
      end
      if (!rstLineN) begin
         txBit = 0;
         rxBit = 0;
      end else if (clkQ && !linkClkOut) begin
         if (txBit == 0) begin
            txCur = (txQ.size() != 0) ? txQ.pop_front() : '0;
         end
         simDataIn <= txCur[WORD_BITS-1-txBit];
         txBit = txBit + 1;
      end else if (!clkQ && linkClkOut) begin
         rxSh = {rxSh[WORD_BITS-2:0], linkDataOut};
         rxBit = rxBit + 1;
         if (rxBit == WORD_BITS) begin
            rxQ.push_back(rxSh);
            rxBit = 0;
            txBit = 0;
            hold = 100; // Last bit stays 1 us past the rise
         end
      end
   end

   // ======================
   // Control line sequencing
   task automatic set_lines(input logic [1:0] m);
      @(posedge clk_sys);
      ctlLine1 <= m[1];
      ctlLine2 <= m[0];
   endtask

   // Waits are scaled down; the handset does not time them
   task automatic start_test(input logic [1:0] m);
      set_lines(m);
      repeat (MODE_WAIT_CYC) @(posedge clk_sys);
      rstLineN <= 1'b0;
      repeat (RESET_LOW_CYC) @(posedge clk_sys);
      rstLineN <= 1'b1;
   endtask
endmodule

// [speech_codec_test_serial_port_tb_top.sv]
/*
 Self-checking bench of the handset end of the speech test serial port.
 Assumes stp_sim_model drives the simulator pins; 100 MHz system clock.
*/
`timescale 1ns/1ps
module speech_codec_test_serial_port_tb_top
   import stp_pkg::*;
;
   localparam int SAMPLE = 12500;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic ctlLine1, ctlLine2, rstLineN, simDataIn;
   logic linkClkOut, linkDataOut, dnReady, upValid, codecReset;
   logic frameStrobe = 1'b0;
   logic dnValid = 1'b0;
   logic upReady = 1'b0;
   logic [WORD_BITS-1:0] dnData = '0;
   logic [WORD_BITS-1:0] upData;
   logic [1:0] testMode;
   logic [31:0] rd;
   int failures = 0;
   int comparisons = 0;
   int codecPulses = 0;

   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      if (codecReset === 1'b1) begin
         codecPulses <= codecPulses + 1;
      end
   end

   stp_port #(.SAMPLE_CYC(SAMPLE)) i_stp_port (.clk_sys(clk_sys), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ctlLine1(ctlLine1), .ctlLine2(ctlLine2),
      .rstLineN(rstLineN), .simDataIn(simDataIn), .linkClkOut(linkClkOut),
      .linkDataOut(linkDataOut), .frameStrobe(frameStrobe), .dnValid(dnValid),
      .dnReady(dnReady), .dnData(dnData), .upValid(upValid), .upReady(upReady),
      .upData(upData), .codecReset(codecReset), .testMode(testMode));

   stp_sim_model i_stp_sim_model (.clk_sys(clk_sys), .linkClkOut(linkClkOut),
      .linkDataOut(linkDataOut), .ctlLine1(ctlLine1), .ctlLine2(ctlLine2),
      .rstLineN(rstLineN), .simDataIn(simDataIn));

   // ======================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Waits for the slave without a limit of its own; the watchdog ends a hang
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk_sys);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wait_clk(input logic lvl, output int n);
      n = 0;
      while (linkClkOut !== lvl && n < 20000) begin
         @(posedge clk_sys);
         n++;
      end
   endtask

   task automatic lows(input int span, output int n);
      n = 0;
      repeat (span) begin
         @(posedge clk_sys);
         if (linkClkOut !== 1'b1) n++;
      end
   endtask

   task automatic strobe();
      frameStrobe <= 1'b1;
      @(posedge clk_sys);
      frameStrobe <= 1'b0;
   endtask

   task automatic begin_test(input logic [1:0] m);
      int p;
      int n;
      p = codecPulses;
      i_stp_sim_model.start_test(m);
      check(32'(codecPulses), 32'(p));
      repeat (20) @(posedge clk_sys);
      check(32'(codecPulses), 32'(p + 1));
      lows(100, n);
      check(32'(n), 32'h0);
   endtask

   task automatic pop_up(input logic [WORD_BITS-1:0] w);
      check({31'h0, upValid}, 32'h1);
      check({19'h0, upData}, {19'h0, w});
      upReady <= 1'b1;
      @(posedge clk_sys);
      upReady <= 1'b0;
      @(posedge clk_sys);
   endtask

   // ======================
   // Scenarios
   task automatic test_regs();
      bus(1'b0, REG_CTRL, 32'h0);
      check(rd, {29'h0, CTRL_MODE_RST, CTRL_SRC_RST});
      bus(1'b1, REG_STATUS, 32'h3);
      bus(1'b0, REG_STATUS, 32'h0);
      check(rd & 32'h7f, 32'h0);
      bus(1'b1, 4'hc, 32'hffffffff);
      bus(1'b0, 4'hc, 32'h0);
      check(rd, 32'h0);
      check({31'h0, linkClkOut}, 32'h1);
   endtask

   task automatic test_decode();
      for (int i = 0; i < 4; i++) begin
         i_stp_sim_model.set_lines(2'(i));
         repeat (10) @(posedge clk_sys);
         check({30'h0, testMode}, 32'(i));
         check({31'h0, linkClkOut}, 32'h1);
      end
      i_stp_sim_model.set_lines(2'h0);
      for (int i = 1; i < 4; i++) begin
         bus(1'b1, REG_CTRL, 32'(i * 2 + 1));
         check({30'h0, testMode}, 32'(i));
         bus(1'b0, REG_CTRL, 32'h0);
         check(rd, 32'(i * 2 + 1));
      end
      bus(1'b1, REG_CTRL, 32'h0);
   endtask

   // Buffer fills with the reader stalled; the third word must wait
   task automatic test_uplink();
      int n;
      i_stp_sim_model.txQ = '{13'h1a5b, 13'h0c3e, 13'h0111};
      begin_test(MODE_UP);
      strobe();
      wait_clk(1'b0, n);
      check(32'(n <= 4), 32'h1);
      repeat (2 * SAMPLE) @(posedge clk_sys);
      lows(12000, n);
      check(32'(n), 32'h0);
      bus(1'b0, REG_STATUS, 32'h0);
      check((rd >> 4) & 32'h3, 32'h2);
      pop_up(13'h1a5b);
      pop_up(13'h0c3e);
      n = 0;
      while (upValid !== 1'b1 && n < 14000) begin
         @(posedge clk_sys);
         n++;
      end
      pop_up(13'h0111);
   endtask

   task automatic test_downlink();
      int n;
      int t;
      begin_test(MODE_DOWN);
      i_stp_sim_model.rxQ.delete();
      dnData <= 13'h1b2d;
      dnValid <= 1'b1;
      strobe();
      n = 0;
      while (dnReady !== 1'b1 && n < 10) begin
         @(posedge clk_sys);
         n++;
      end
      dnValid <= 1'b0;
      check(32'(n < 10), 32'h1);
      wait_clk(1'b0, n);
      wait_clk(1'b1, t);
      check(32'(t), 32'(LINK_HALF));
      n = 0;
      while (i_stp_sim_model.rxQ.size() == 0 && n < 13000) begin
         @(posedge clk_sys);
         n++;
      end
      check({19'h0, i_stp_sim_model.rxQ[0]}, 32'h1b2d);
      lows(12000, n);
      check(32'(n), 32'h0);
      bus(1'b0, REG_WORDS, 32'h0);
      check(rd, 32'h4);
      i_stp_sim_model.set_lines(MODE_NORMAL);
      repeat (10) @(posedge clk_sys);
      check({30'h0, testMode}, 32'h0);
      check({31'h0, linkClkOut}, 32'h1);
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      test_regs();
      test_decode();
      test_uplink();
      test_downlink();
      conclude();
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      failures++;
      conclude();
   end
endmodule
